// ===== core/sts_device.sv
// Target end: serial EEPROM with software protect plus sensor register set.
// Assumes scl and sda are synchronous to core_clk and slow against it.
`timescale 1ns/1ns
module sts_device #(
  parameter int WRITE_CYCLE = sts_pkg::WRITE_CYCLE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bus
  sts_bus_if.device bus,
  // Address select straps
  input wire logic addr_select_pin0,
  input wire logic addr_select_pin1,
  input wire logic addr_select_pin2,
  input wire logic addr_select_pin0_hv,
  // Status
  output logic write_busy,
  output logic reversible_protect,
  output logic permanent_protect
);
  import sts_pkg::*;

  logic [7:0] ee_mem [EE_DEPTH];
  logic [15:0] ts_reg [TS_REG_COUNT];

  sts_dev_state_t state_q, state_d;
  sts_target_t tgt_q, tgt_d;
  logic scl_q, sda_q;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] byte_n_q, byte_n_d;
  logic [7:0] sh_q, sh_d;
  logic rd_q, rd_d;
  logic [2:0] cmd_q, cmd_d;
  logic [7:0] ee_addr_q, ee_addr_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] hi_q, hi_d;
  logic lo_sel_q, lo_sel_d;
  logic rack_q, rack_d;
  logic pend_q, pend_d;
  logic [31:0] busy_q, busy_d;
  logic wp_rev_q, wp_rev_d;
  logic wp_perm_q, wp_perm_d;
  logic sda_oe_q, sda_oe_d;
  logic mem_we, ts_we;
  logic start_c, stop_c, rise_c, fall_c;
  logic ack_c;
  logic [7:0] tx_byte;
  logic [15:0] ts_word;
  logic [2:0] sa_ee, sa_ts;

  assign start_c = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop_c = scl_q & bus.scl & ~sda_q & bus.sda;
  assign rise_c = ~scl_q & bus.scl;
  assign fall_c = scl_q & ~bus.scl;
  assign sa_ee = {addr_select_pin2, addr_select_pin1, addr_select_pin0};
  assign sa_ts = {addr_select_pin2, addr_select_pin1, addr_select_pin0 | addr_select_pin0_hv};
  assign ts_word = (ptr_q <= TS_PTR_LAST) ? ts_reg[ptr_q[3:0]] : TS_REG_RESET;
  assign tx_byte = (tgt_q == STS_TGT_EE) ? ee_mem[ee_addr_q] : (lo_sel_q ? ts_word[7:0] : ts_word[15:8]);

  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = sda_oe_q;
  assign write_busy = (busy_q != 32'h0);
  assign reversible_protect = wp_rev_q;
  assign permanent_protect = wp_perm_q;

  // Acknowledge decision for a completed received byte in sh_q
  always_comb
  begin
    ack_c = 1'b0;
    if (byte_n_q == 3'h0)
    begin
      case (sh_q[7:4])
        TS_TYPE: ack_c = (sh_q[3:1] == sa_ts);
        EE_TYPE: ack_c = (sh_q[3:1] == sa_ee);
        PROT_TYPE:
        begin
          if (wp_perm_q)
            ack_c = 1'b0;
          else if (sh_q[0])
            ack_c = (sh_q[3:1] == CMD_QUERY_PERMANENT_PROTECT) ||
                    ((sh_q[3:1] == CMD_QUERY_REVERSIBLE_PROTECT) && !wp_rev_q);
          else if (!addr_select_pin0_hv)
            ack_c = 1'b0;
          else if (sh_q[3:1] == CMD_SET_REVERSIBLE_PROTECT)
            ack_c = !wp_rev_q;
          else
            ack_c = (sh_q[3:1] == CMD_CLEAR_REVERSIBLE_PROTECT) ||
                    (sh_q[3:1] == CMD_SET_PERMANENT_PROTECT);
        end
        default: ack_c = 1'b0;
      endcase
    end
    else
    begin
      case (tgt_q)
        STS_TGT_EE: ack_c = !rd_q;
        STS_TGT_TS: ack_c = !rd_q && (byte_n_q <= 3'h3);
        STS_TGT_PROT: ack_c = !rd_q && (byte_n_q <= 3'h2);
        default: ack_c = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    state_d = state_q;
    tgt_d = tgt_q;
    cnt_d = cnt_q;
    byte_n_d = byte_n_q;
    sh_d = sh_q;
    rd_d = rd_q;
    cmd_d = cmd_q;
    ee_addr_d = ee_addr_q;
    ptr_d = ptr_q;
    hi_d = hi_q;
    lo_sel_d = lo_sel_q;
    rack_d = rack_q;
    pend_d = pend_q;
    busy_d = busy_q;
    wp_rev_d = wp_rev_q;
    wp_perm_d = wp_perm_q;
    sda_oe_d = sda_oe_q;
    mem_we = 1'b0;
    ts_we = 1'b0;
    if (busy_q != 32'h0)
    begin
      busy_d = busy_q - 32'h1;
      state_d = STS_D_IDLE;
      sda_oe_d = 1'b0;
    end
    else if (start_c)
    begin
      state_d = STS_D_RX;
      tgt_d = STS_TGT_NONE;
      cnt_d = 4'h0;
      byte_n_d = 3'h0;
      pend_d = 1'b0;
      sda_oe_d = 1'b0;
    end
    else if (stop_c)
    begin
      state_d = STS_D_IDLE;
      sda_oe_d = 1'b0;
      pend_d = 1'b0;
      // Write cycle only for a stop in the slot after an acknowledge
      if (pend_q && state_q == STS_D_RX && cnt_q == 4'h1)
      begin
        busy_d = 32'(WRITE_CYCLE);
        if (tgt_q == STS_TGT_PROT)
        begin
          case (cmd_q)
            CMD_SET_REVERSIBLE_PROTECT: wp_rev_d = 1'b1;
            CMD_CLEAR_REVERSIBLE_PROTECT: wp_rev_d = 1'b0;
            CMD_SET_PERMANENT_PROTECT: wp_perm_d = 1'b1;
            default: wp_rev_d = wp_rev_q;
          endcase
        end
      end
    end
    else
    begin
      case (state_q)
        STS_D_RX:
        begin
          if (rise_c)
          begin
            sh_d = {sh_q[6:0], bus.sda};
            cnt_d = cnt_q + 4'h1;
          end
          else if (fall_c && cnt_q == BITS_PER_BYTE)
          begin
            cnt_d = 4'h0;
            byte_n_d = (byte_n_q == BYTE_IDX_MAX) ? BYTE_IDX_MAX : byte_n_q + 3'h1;
            state_d = ack_c ? STS_D_ACK : STS_D_IDLE;
            sda_oe_d = ack_c;
            if (byte_n_q == 3'h0)
            begin
              rd_d = sh_q[0];
              cmd_d = sh_q[3:1];
              lo_sel_d = 1'b0;
              tgt_d = (sh_q[7:4] == EE_TYPE) ? STS_TGT_EE :
                      (sh_q[7:4] == TS_TYPE) ? STS_TGT_TS : STS_TGT_PROT;
            end
            else if (ack_c && tgt_q == STS_TGT_EE)
            begin
              if (byte_n_q == 3'h1)
                ee_addr_d = sh_q;
              else
              begin
                // Lower half not modified when protected
                mem_we = ee_addr_q[7] || !(wp_rev_q || wp_perm_q);
                ee_addr_d = {ee_addr_q[7:4], ee_addr_q[3:0] + 4'h1};
                pend_d = 1'b1;
              end
            end
            else if (ack_c && tgt_q == STS_TGT_TS)
            begin
              if (byte_n_q == 3'h1)
                ptr_d = sh_q;
              else if (byte_n_q == 3'h2)
                hi_d = sh_q;
              else
                ts_we = (ptr_q <= TS_PTR_LAST);
            end
            else if (ack_c && tgt_q == STS_TGT_PROT && byte_n_q == 3'h2)
              pend_d = 1'b1;
          end
        end
        STS_D_ACK:
        begin
          if (fall_c)
          begin
            sda_oe_d = 1'b0;
            state_d = STS_D_RX;
            if (rd_q && (tgt_q == STS_TGT_EE || tgt_q == STS_TGT_TS))
            begin
              state_d = STS_D_TX;
              sh_d = tx_byte;
              sda_oe_d = ~tx_byte[7];
              lo_sel_d = ~lo_sel_q;
              if (tgt_q == STS_TGT_EE)
                ee_addr_d = ee_addr_q + 8'h1;
            end
          end
        end
        STS_D_TX:
        begin
          if (rise_c)
            cnt_d = cnt_q + 4'h1;
          else if (fall_c)
          begin
            if (cnt_q == BITS_PER_BYTE)
            begin
              state_d = STS_D_RACK;
              sda_oe_d = 1'b0;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_oe_d = ~sh_q[6];
            end
          end
        end
        STS_D_RACK:
        begin
          if (rise_c)
            rack_d = ~bus.sda;
          else if (fall_c)
          begin
            cnt_d = 4'h0;
            if (!rack_q)
              state_d = STS_D_IDLE;
            else
            begin
              state_d = STS_D_TX;
              sh_d = tx_byte;
              sda_oe_d = ~tx_byte[7];
              lo_sel_d = ~lo_sel_q;
              if (tgt_q == STS_TGT_EE)
                ee_addr_d = ee_addr_q + 8'h1;
            end
          end
        end
        default: state_d = STS_D_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= STS_D_IDLE;
      tgt_q <= STS_TGT_NONE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      byte_n_q <= 3'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      cmd_q <= 3'h0;
      ee_addr_q <= 8'h00;
      ptr_q <= 8'h00;
      hi_q <= 8'h00;
      lo_sel_q <= 1'b0;
      rack_q <= 1'b0;
      pend_q <= 1'b0;
      busy_q <= 32'h0;
      wp_rev_q <= 1'b0;
      wp_perm_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tgt_q <= tgt_d;
      scl_q <= bus.scl;
      sda_q <= bus.sda;
      cnt_q <= cnt_d;
      byte_n_q <= byte_n_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      cmd_q <= cmd_d;
      ee_addr_q <= ee_addr_d;
      ptr_q <= ptr_d;
      hi_q <= hi_d;
      lo_sel_q <= lo_sel_d;
      rack_q <= rack_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      wp_rev_q <= wp_rev_d;
      wp_perm_q <= wp_perm_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // Array storage; EEPROM contents are not reset, sensor registers reset to TS_REG_RESET
  always_ff @(posedge core_clk)
  begin
    if (mem_we)
      ee_mem[ee_addr_q] <= sh_q;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < TS_REG_COUNT; i++)
        ts_reg[i] <= TS_REG_RESET;
    end
    else if (ts_we)
      ts_reg[ptr_q[3:0]] <= {hi_q, sh_q};
  end

endmodule : sts_device

// ===== core/sts_pkg.sv
// Shared constants and types for the module-sensor two-wire link.
// Assumes a single 100 MHz core clock on both ends.
package sts_pkg;

  // Clock and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int WRITE_CYCLE_US = 5000;
  localparam int WRITE_CYCLE_CYCLES = (WRITE_CYCLE_US * 1000) / CLK_PERIOD_NS;

  // Select code type nibbles
  localparam logic [3:0] EE_TYPE = 4'hA;
  localparam logic [3:0] TS_TYPE = 4'h3;
  localparam logic [3:0] PROT_TYPE = 4'h6;

  // Protect-class command codes in select bits 3:1
  localparam logic [2:0] CMD_SET_PERMANENT_PROTECT = 3'h0;
  localparam logic [2:0] CMD_SET_REVERSIBLE_PROTECT = 3'h1;
  localparam logic [2:0] CMD_CLEAR_REVERSIBLE_PROTECT = 3'h3;
  localparam logic [2:0] CMD_QUERY_PERMANENT_PROTECT = 3'h0;
  localparam logic [2:0] CMD_QUERY_REVERSIBLE_PROTECT = 3'h1;

  // Memory geometry
  localparam int EE_DEPTH = 256;
  localparam int TS_REG_COUNT = 9;
  localparam logic [7:0] TS_PTR_LAST = 8'h08;
  localparam logic [15:0] TS_REG_RESET = 16'h0000;

  // Byte counter limits
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] BYTE_IDX_MAX = 3'h4;

  typedef enum logic [2:0] {
    STS_D_IDLE = 3'b000,
    STS_D_RX = 3'b001,
    STS_D_ACK = 3'b010,
    STS_D_TX = 3'b011,
    STS_D_RACK = 3'b100
  } sts_dev_state_t;

  typedef enum logic [1:0] {
    STS_TGT_NONE = 2'b00,
    STS_TGT_EE = 2'b01,
    STS_TGT_TS = 2'b10,
    STS_TGT_PROT = 2'b11
  } sts_target_t;

  typedef enum logic [1:0] {
    STS_OP_START = 2'b00,
    STS_OP_STOP = 2'b01,
    STS_OP_WRITE = 2'b10,
    STS_OP_READ = 2'b11
  } sts_op_t;

  typedef enum logic [1:0] {
    STS_H_IDLE = 2'b00,
    STS_H_START = 2'b01,
    STS_H_STOP = 2'b10,
    STS_H_BYTE = 2'b11
  } sts_host_state_t;

endpackage : sts_pkg

// ===== core/sts_bus_if.sv
// Two-wire bus between the master controller and the sensor device.
// Open-drain: a line is low while any party enables its driver.
`timescale 1ns/1ns
interface sts_bus_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // Wired-and resolution of both lines
  assign scl = scl_host_oe ? scl_host_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);

  modport host (
    output scl_host_o,
    output scl_host_oe,
    output sda_host_o,
    output sda_host_oe,
    input scl,
    input sda
  );

  modport device (
    output sda_dev_o,
    output sda_dev_oe,
    input scl,
    input sda
  );
endinterface : sts_bus_if

// ===== core/sts_host.sv
// Master end: byte-level two-wire controller driven by a simple op port.
// Assumes the device never stretches the clock.
`timescale 1ns/1ns
module sts_host #(
  parameter int QTR_CYCLES = sts_pkg::SCL_QTR_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bus
  sts_bus_if.host bus,
  // Operation request
  input wire logic op_valid,
  input wire sts_pkg::sts_op_t op_code,
  input wire logic [7:0] op_wdata,
  input wire logic op_send_ack,
  output logic op_ready,
  // Operation result
  output logic op_done,
  output logic [7:0] op_rdata,
  output logic op_ack_seen
);
  import sts_pkg::*;

  sts_host_state_t state_q, state_d;
  logic [15:0] div_q, div_d;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic rd_q, rd_d;
  logic ack_q, ack_d;
  logic samp_q, samp_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d;
  logic seen_q, seen_d;
  logic scl_oe_q, scl_oe_d;
  logic sda_oe_q, sda_oe_d;
  logic tick;

  assign tick = (div_q == 16'(QTR_CYCLES - 1));
  assign op_ready = (state_q == STS_H_IDLE);
  assign op_done = done_q;
  assign op_rdata = rdata_q;
  assign op_ack_seen = seen_q;
  assign bus.scl_host_o = 1'b0;
  assign bus.sda_host_o = 1'b0;
  assign bus.scl_host_oe = scl_oe_q;
  assign bus.sda_host_oe = sda_oe_q;

  always_comb
  begin
    state_d = state_q;
    div_d = (state_q == STS_H_IDLE || tick) ? 16'h0 : div_q + 16'h1;
    qtr_d = qtr_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rd_d = rd_q;
    ack_d = ack_q;
    samp_d = samp_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    seen_d = seen_q;
    if (state_q == STS_H_IDLE && op_valid)
    begin
      qtr_d = 2'h0;
      bit_d = 4'h0;
      sh_d = op_wdata;
      rd_d = (op_code == STS_OP_READ);
      // Caller clears send_ack on last byte
      ack_d = op_send_ack;
      case (op_code)
        STS_OP_START: state_d = STS_H_START;
        STS_OP_STOP: state_d = STS_H_STOP;
        default: state_d = STS_H_BYTE;
      endcase
    end
    else if (state_q != STS_H_IDLE && tick)
    begin
      qtr_d = qtr_q + 2'h1;
      if (qtr_q == 2'h2)
        samp_d = bus.sda;
      if (qtr_q == 2'h3)
      begin
        if (state_q != STS_H_BYTE)
        begin
          state_d = STS_H_IDLE;
          done_d = 1'b1;
        end
        else if (bit_q == BITS_PER_BYTE)
        begin
          state_d = STS_H_IDLE;
          done_d = 1'b1;
          rdata_d = sh_q;
          seen_d = rd_q ? ack_q : ~samp_q;
        end
        else
        begin
          bit_d = bit_q + 4'h1;
          sh_d = {sh_q[6:0], samp_q};
        end
      end
    end
  end

  // Line drive for the quarter being entered
  always_comb
  begin
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    case (state_d)
      STS_H_START:
      begin
        scl_oe_d = (qtr_d == 2'h0) || (qtr_d == 2'h3);
        sda_oe_d = (qtr_d >= 2'h2);
      end
      STS_H_STOP:
      begin
        scl_oe_d = (qtr_d == 2'h0);
        sda_oe_d = (qtr_d <= 2'h1);
      end
      STS_H_BYTE:
      begin
        scl_oe_d = (qtr_d == 2'h0) || (qtr_d == 2'h3);
        sda_oe_d = (bit_d < BITS_PER_BYTE) ? (~rd_d & ~sh_d[7]) : (rd_d & ack_d);
      end
      default: scl_oe_d = scl_oe_q;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= STS_H_IDLE;
      div_q <= 16'h0;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      samp_q <= 1'b1;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      seen_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      div_q <= div_d;
      qtr_q <= qtr_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      samp_q <= samp_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      seen_q <= seen_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

endmodule : sts_host

// ===== bench/sts_bus_assertions.sv
// Bus-level checks on the two-wire link between host and device.
// Assumes both ends run on core_clk with the host at eight cycles a quarter.
`timescale 1ns/1ns
module sts_bus_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Host drivers
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  // Device drivers
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  property p_start_by_host;
    s_start |-> sda_host_oe;
  endproperty
  property p_stop_released;
    s_stop |=> !sda_dev_oe;
  endproperty
  property p_dev_release;
    $rose(sda_dev_oe) |-> ##[1:600] !sda_dev_oe;
  endproperty
  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty
  property p_scl_low;
    $fell(scl) |-> !scl [*4];
  endproperty
  property p_start_dev_quiet;
    s_start |-> !sda_dev_oe;
  endproperty
  property p_dev_change_low;
    $changed(sda_dev_oe) |-> !scl && !$past(scl);
  endproperty
  property p_dev_hold_high;
    $rose(scl) |-> $stable(sda_dev_oe) [*8];
  endproperty

  a_start_by_host: assert property (p_start_by_host) else $error("start not made by host");
  a_stop_released: assert property (p_stop_released) else $error("device drives sda after stop");
  a_dev_release: assert property (p_dev_release) else $error("device holds sda too long");
  a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
  a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
  a_start_dev_quiet: assert property (p_start_dev_quiet) else $error("device drives sda at a start");
  a_dev_change_low: assert property (p_dev_change_low) else $error("device sda change near scl high");
  a_dev_hold_high: assert property (p_dev_hold_high) else $error("device sda moved while scl high");
endmodule : sts_bus_assertions

// ===== bench/tb.sv
// Self-checking bench: host and device joined by the two-wire bus.
// Assumes short quarter and write-cycle parameters set below.
`timescale 1ns/1ns
module tb;
  import sts_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic op_valid = 1'b0;
  sts_op_t op_code = STS_OP_START;
  logic [7:0] op_wdata = 8'h00;
  logic op_send_ack = 1'b0;
  logic op_ready, op_done, op_ack_seen, write_busy, reversible_protect, permanent_protect;
  logic [7:0] op_rdata;
  logic [2:0] pins = 3'h5;
  logic hv = 1'b0;
  int failures = 0;
  int num_checks = 0;

  always #5 core_clk = ~core_clk;

  sts_bus_if sts_bus_if_i ();
  sts_host #(.QTR_CYCLES(8)) sts_host_i (.core_clk(core_clk), .nrst(nrst), .bus(sts_bus_if_i.host),
    .op_valid(op_valid), .op_code(op_code), .op_wdata(op_wdata), .op_send_ack(op_send_ack),
    .op_ready(op_ready), .op_done(op_done), .op_rdata(op_rdata), .op_ack_seen(op_ack_seen));
  sts_device #(.WRITE_CYCLE(400)) sts_device_i (.core_clk(core_clk), .nrst(nrst), .bus(sts_bus_if_i.device),
    .addr_select_pin0(pins[0]), .addr_select_pin1(pins[1]), .addr_select_pin2(pins[2]),
    .addr_select_pin0_hv(hv), .write_busy(write_busy), .reversible_protect(reversible_protect),
    .permanent_protect(permanent_protect));
  sts_bus_assertions sts_bus_assertions_i (.core_clk(core_clk), .nrst(nrst),
    .scl_host_o(sts_bus_if_i.scl_host_o), .scl_host_oe(sts_bus_if_i.scl_host_oe),
    .sda_host_o(sts_bus_if_i.sda_host_o), .sda_host_oe(sts_bus_if_i.sda_host_oe),
    .sda_dev_o(sts_bus_if_i.sda_dev_o), .sda_dev_oe(sts_bus_if_i.sda_dev_oe),
    .scl(sts_bus_if_i.scl), .sda(sts_bus_if_i.sda));

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One host operation, waiting a bounded time for its completion pulse
  task automatic op(input sts_op_t c, input logic [7:0] d, input logic a);
    int n = 0;
    @(negedge core_clk);
    op_valid = 1'b1;
    op_code = c;
    op_wdata = d;
    op_send_ack = a;
    @(negedge core_clk);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 2000)
    begin
      failures++;
      test_done();
    end
  endtask : op

  task automatic s();
    op(STS_OP_START, 8'h00, 1'b0);
  endtask : s

  task automatic p();
    op(STS_OP_STOP, 8'h00, 1'b0);
  endtask : p

  task automatic w(input logic [7:0] d, input logic a);
    op(STS_OP_WRITE, d, 1'b0);
    check({7'h00, op_ack_seen}, {7'h00, a});
  endtask : w

  task automatic r(input logic a, input logic [7:0] e);
    op(STS_OP_READ, 8'h00, a);
    check(op_rdata, e);
  endtask : r

  task automatic wait_idle();
    int n = 0;
    repeat (2) @(negedge core_clk);
    while (write_busy !== 1'b0 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 2000)
    begin
      failures++;
      test_done();
    end
  endtask : wait_idle

  // Protect-class instruction or query: select, address byte, data byte
  task automatic prot(input logic [7:0] sel, input logic a, input logic q);
    s();
    w(sel, a);
    w(8'h00, a & ~q);
    w(8'h00, a & ~q);
    p();
    wait_idle();
  endtask : prot

  task automatic t_eeprom();
    s();
    w(8'hAA, 1'b1);
    w(8'hFE, 1'b1);
    w(8'h5A, 1'b1);
    w(8'hC3, 1'b1);
    p();
    check({7'h00, write_busy}, 8'h01);
    s();
    w(8'hAA, 1'b0);
    p();
    wait_idle();
    s();
    w(8'hAA, 1'b1);
    w(8'h00, 1'b1);
    w(8'h3C, 1'b1);
    w(8'h96, 1'b1);
    p();
    wait_idle();
    s();
    w(8'hAA, 1'b1);
    w(8'hFE, 1'b1);
    s();
    w(8'hAB, 1'b1);
    r(1'b1, 8'h5A);
    r(1'b1, 8'hC3);
    r(1'b0, 8'h3C);
    p();
    s();
    w(8'hAB, 1'b1);
    r(1'b0, 8'h96);
    p();
  endtask : t_eeprom

  task automatic t_protect();
    @(negedge core_clk);
    hv = 1'b1;
    prot(8'h61, 1'b1, 1'b1);
    prot(8'h63, 1'b1, 1'b1);
    prot(8'h62, 1'b1, 1'b0);
    check({7'h00, reversible_protect}, 8'h01);
    prot(8'h62, 1'b0, 1'b0);
    prot(8'h63, 1'b0, 1'b1);
    prot(8'h61, 1'b1, 1'b1);
    s();
    w(8'hAA, 1'b1);
    w(8'h10, 1'b1);
    op(STS_OP_WRITE, 8'h77, 1'b0);
    p();
    wait_idle();
    prot(8'h66, 1'b1, 1'b0);
    check({7'h00, reversible_protect}, 8'h00);
    prot(8'h66, 1'b1, 1'b0);
    prot(8'h62, 1'b1, 1'b0);
    prot(8'h60, 1'b1, 1'b0);
    check({7'h00, permanent_protect}, 8'h01);
    prot(8'h66, 1'b0, 1'b0);
    prot(8'h60, 1'b0, 1'b0);
    prot(8'h61, 1'b0, 1'b1);
    prot(8'h63, 1'b0, 1'b1);
    s();
    w(8'hAA, 1'b1);
    w(8'hFE, 1'b1);
    s();
    w(8'hAB, 1'b1);
    r(1'b0, 8'h5A);
    p();
    @(negedge core_clk);
    hv = 1'b0;
  endtask : t_protect

  task automatic t_sensor();
    s();
    w(8'h3A, 1'b1);
    w(8'h00, 1'b1);
    w(8'h12, 1'b1);
    w(8'h34, 1'b1);
    p();
    s();
    w(8'h3A, 1'b1);
    w(8'h08, 1'b1);
    w(8'hAB, 1'b1);
    w(8'hCD, 1'b1);
    p();
    s();
    w(8'h3B, 1'b1);
    r(1'b1, 8'hAB);
    r(1'b1, 8'hCD);
    p();
    s();
    w(8'h3A, 1'b1);
    w(8'h00, 1'b1);
    s();
    w(8'h3B, 1'b1);
    r(1'b1, 8'h12);
    r(1'b0, 8'h34);
    p();
    s();
    w(8'h3A, 1'b1);
    w(8'h08, 1'b1);
    p();
    @(negedge core_clk);
    pins = 3'h4;
    hv = 1'b1;
    s();
    w(8'h3B, 1'b1);
    r(1'b1, 8'hAB);
    r(1'b0, 8'hCD);
    p();
    @(negedge core_clk);
    hv = 1'b0;
    s();
    w(8'h3A, 1'b0);
    p();
    s();
    w(8'h39, 1'b1);
    r(1'b0, 8'hAB);
    p();
    s();
    w(8'h38, 1'b1);
    w(8'h00, 1'b1);
    w(8'h12, 1'b1);
    w(8'h34, 1'b1);
    w(8'h56, 1'b0);
    p();
    s();
    w(8'h38, 1'b1);
    w(8'h09, 1'b1);
    s();
    w(8'h39, 1'b1);
    r(1'b1, 8'h00);
    r(1'b0, 8'h00);
    p();
  endtask : t_sensor

  initial
  begin
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    t_eeprom();
    t_protect();
    t_sensor();
    test_done();
  end
endmodule : tb
